// [shared/spn_pkg.sv]
`default_nettype none
package spn_pkg;
  // Array geometry: 18 significant address bits, 3 address bytes on the wire
  localparam int ADDR_W = 18;
  localparam int ADDR_BYTES = 3;
  localparam int ADDR_PAD = 8 * ADDR_BYTES - ADDR_W;
  // Command codes
  localparam logic [7:0] OP_SET_WEL = 8'h06; // set_write_latch_cmd
  localparam logic [7:0] OP_CLR_WEL = 8'h04; // clear_write_latch_cmd
  localparam logic [7:0] OP_STAT_RD = 8'h05; // status_read_cmd
  localparam logic [7:0] OP_STAT_WR = 8'h01; // status_write_cmd
  localparam logic [7:0] OP_MEM_RD = 8'h03;
  localparam logic [7:0] OP_MEM_WR = 8'h02;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  // Status byte layout
  localparam int ST_PPEN = 7; // protect_pin_enable_bit
  localparam int ST_BP_HI = 3;
  localparam int ST_BP_LO = 2;
  localparam int ST_WEL = 1;
  localparam logic [7:0] ST_RST = 8'h00;
  localparam logic [7:0] ST_WR_MASK = 8'h8C; // Bits software may write
  // Frame lengths in serial bits
  localparam logic [5:0] BITS_OP = 6'h08;
  localparam logic [5:0] BITS_STAT = 6'h10;
  localparam logic [5:0] BITS_MEM = 6'h28;
  // Serial clock timing
  localparam int REF_MHZ = 250;
  localparam int SCK_MAX_MHZ = 40;
  // Least half period, rounded up to whole reference cycles
  localparam int SCK_HALF_CYC =
    (REF_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
endpackage : spn_pkg
`default_nettype wire

// [shared/spn_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface spn_if;
  logic cs_n; // Chip select, low active
  logic sck; // Serial clock from the master
  logic si; // Master to device data
  logic so; // Device to master data
  logic so_oe; // High while the device drives its output
  logic wp_n; // Write protect, low active
  logic hold_n; // Hold, low active
  logic so_line; // Resolved output wire
  // Undriven output floats; a pull-up makes it read high
  assign so_line = so_oe ? so : 1'b1;
  modport dev (
    input cs_n, sck, si, wp_n, hold_n,
    output so, so_oe
  );
  modport host (
    output cs_n, sck, si, wp_n, hold_n,
    input so_line
  );
endinterface : spn_if
`default_nettype wire

// [verilog/spn_host.sv]
`timescale 1ns/100ps
`default_nettype none
module spn_host #(
  parameter int ADDR_W = spn_pkg::ADDR_W, // Address width
  parameter int HALF = spn_pkg::SCK_HALF_CYC, // Serial half period
  parameter int DEPTH = 2, // Read buffer entries
  parameter int DW = 8 // Read buffer width
) (
  spn_if.host bus, // Serial link
  input wire logic ref_clk_in, // System clock
  input wire logic rstn_in, // Synchronous reset, low
  input wire logic cmd_valid_in, // Command offered
  output logic cmd_ready_out, // Command taken this cycle
  input wire logic [7:0] cmd_op_in, // Command code
  input wire logic [ADDR_W-1:0] cmd_addr_in, // Byte location
  input wire logic [7:0] cmd_data_in, // Write byte
  input wire logic hold_req_in, // Request a pause
  input wire logic wp_n_in, // Write protect level
  output logic rd_valid_out, // Read byte waiting
  input wire logic rd_ready_in, // Consumer takes it
  output logic [DW-1:0] rd_data_out // Read byte
);
  typedef enum logic [4:0] {
    HS_IDLE = 5'h01,
    HS_LOW = 5'h02,
    HS_HIGH = 5'h04,
    HS_TAIL = 5'h08,
    HS_GAP = 5'h10
  } spn_hstate_t;
  localparam logic [7:0] HALF_M1 = 8'(HALF - 1);
  spn_hstate_t state_q; // Frame sequencer
  logic cs_q, sck_q, si_q; // Pin drivers
  logic hold_n_q, wp_n_q; // Pin drivers
  logic [7:0] cnt_q; // Half period counter
  logic [5:0] bits_q; // Bits left in frame
  logic [39:0] tx_q; // Outgoing frame, left aligned
  logic [7:0] rx_q; // Last eight bits seen
  logic rd_q; // Frame returns a byte
  logic so_s1, so_s2; // Output pin synchroniser
  logic is_rd, is_mem, is_st, room, push;
  logic [DW-1:0] buf_q [0:DEPTH-1]; // Read buffer storage
  logic [$clog2(DEPTH+1)-1:0] fill_q; // Entries held
  logic [$clog2(DEPTH)-1:0] wp_q, rp_q; // Buffer pointers
  // Command classes
  assign is_rd = (cmd_op_in == spn_pkg::OP_MEM_RD) ||
                 (cmd_op_in == spn_pkg::OP_STAT_RD);
  assign is_mem = (cmd_op_in == spn_pkg::OP_MEM_RD) ||
                  (cmd_op_in == spn_pkg::OP_MEM_WR);
  assign is_st = (cmd_op_in == spn_pkg::OP_STAT_RD) ||
                 (cmd_op_in == spn_pkg::OP_STAT_WR);
  assign room = fill_q < DEPTH;
  // A read waits for buffer room, so a stalled consumer stalls reads but not other commands
  assign cmd_ready_out = (state_q == HS_IDLE) && (room || !is_rd);
  assign push = (state_q == HS_TAIL) && (cnt_q == 8'h00) && rd_q;
  assign bus.cs_n = cs_q;
  assign bus.sck = sck_q;
  assign bus.si = si_q;
  assign bus.hold_n = hold_n_q;
  assign bus.wp_n = wp_n_q;
  // Device output changes on the falling edge; two flops before use
  always_ff @(posedge ref_clk_in)
  begin
    so_s1 <= bus.so_line;
    so_s2 <= so_s1;
  end
  // Hold and protect pins; hold moves only while the clock is low
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      hold_n_q <= 1'b1;
      wp_n_q <= 1'b1;
    end
    else
    begin
      wp_n_q <= wp_n_in;
      if (!sck_q)
        hold_n_q <= !hold_req_in;
    end
  end
  // Frame sequencer: mode 0, select falls before each command
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      state_q <= HS_IDLE;
      cs_q <= 1'b1;
      sck_q <= 1'b0;
      si_q <= 1'b0;
      cnt_q <= 8'h00;
      bits_q <= 6'h00;
      tx_q <= 40'h0;
      rx_q <= 8'h00;
      rd_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        HS_IDLE:
          if (cmd_valid_in && cmd_ready_out)
          begin
            // Fresh select per command, MSB first
            cs_q <= 1'b0;
            rd_q <= is_rd;
            cnt_q <= HALF_M1;
            state_q <= HS_LOW;
            si_q <= cmd_op_in[7];
            if (is_mem)
            begin
              bits_q <= spn_pkg::BITS_MEM;
              tx_q <= {cmd_op_in, (spn_pkg::ADDR_PAD)'(0),
                       cmd_addr_in, cmd_data_in};
            end
            else
            begin
              bits_q <= is_st ? spn_pkg::BITS_STAT : spn_pkg::BITS_OP;
              tx_q <= {cmd_op_in, cmd_data_in, 24'h0};
            end
          end
        HS_LOW:
          // Also pause on the edge at which hold is about to fall, so that
          // hold never moves together with a rising clock
          if (hold_n_q && !hold_req_in)
          begin
            if (cnt_q == 8'h00)
            begin
              sck_q <= 1'b1;
              rx_q <= {rx_q[6:0], so_s2};
              bits_q <= bits_q - 6'h01;
              cnt_q <= HALF_M1;
              state_q <= HS_HIGH;
            end
            else
              cnt_q <= cnt_q - 8'h01;
          end
        HS_HIGH:
          if (cnt_q == 8'h00)
          begin
            sck_q <= 1'b0;
            cnt_q <= HALF_M1;
            if (bits_q == 6'h00)
              state_q <= HS_TAIL;
            else
            begin
              tx_q <= {tx_q[38:0], 1'b0};
              si_q <= tx_q[38];
              state_q <= HS_LOW;
            end
          end
          else
            cnt_q <= cnt_q - 8'h01;
        HS_TAIL:
          if (cnt_q == 8'h00)
          begin
            cs_q <= 1'b1;
            cnt_q <= HALF_M1;
            state_q <= HS_GAP;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        default:
          if (cnt_q == 8'h00)
            state_q <= HS_IDLE;
          else
            cnt_q <= cnt_q - 8'h01;
      endcase
    end
  end
  // Read buffer; pop side stalls when the consumer is not ready
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      fill_q <= '0;
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (push)
      begin
        buf_q[wp_q] <= rx_q;
        wp_q <= wp_q + 1'b1;
      end
      if (rd_valid_out && rd_ready_in)
        rp_q <= rp_q + 1'b1;
      fill_q <= fill_q + (push ? 1'b1 : 1'b0)
        - ((rd_valid_out && rd_ready_in) ? 1'b1 : 1'b0);
    end
  end
  assign rd_valid_out = fill_q != '0;
  assign rd_data_out = buf_q[rp_q];
endmodule : spn_host
`default_nettype wire

// [verilog/spn_dev.sv]
`timescale 1ns/100ps
`default_nettype none
module spn_dev #(
  parameter int ADDR_W = spn_pkg::ADDR_W // Address width
) (
  spn_if.dev bus, // Serial link, clocked by its own clock
  input wire logic ref_clk_in, // System clock
  input wire logic rstn_in, // Synchronous reset, low
  output logic [7:0] status_out, // Status byte
  output logic mode3_out // Last selection used mode 3
);
  typedef enum logic [6:0] {
    DS_CMD = 7'h01,
    DS_ADR = 7'h02,
    DS_WR = 7'h04,
    DS_RD = 7'h08,
    DS_SWR = 7'h10,
    DS_SRD = 7'h20,
    DS_SKIP = 7'h40
  } spn_dstate_t;

  // Link domain state, cleared while deselected except mode3_q
  spn_dstate_t state_q; // Frame phase
  logic [2:0] bit_q; // Bit within byte
  logic [6:0] sh_q; // Partial byte
  logic [1:0] abyte_q; // Address bytes taken
  logic [ADDR_W-1:0] addr_q; // Byte location
  logic rd_q; // Memory command is a read
  logic set_req_q; // Latch set seen this selection
  logic clr_req_q; // Latch clear seen this selection
  logic srw_req_q; // Accepted status write
  logic [7:0] srw_val_q; // Status byte to store
  logic drive_q; // Output active
  logic so_q; // Output bit
  logic mode3_q; // Clock level at select fall
  // Status copy brought into the link domain
  logic [7:0] st_s1, st_s2;
  // Link byte assembly
  logic byte_done; // Eighth bit arrives this edge
  logic [7:0] byte_v; // Completed byte
  logic [7:0] out_byte; // Byte being returned
  logic wel_s, ppen_s; // Synchronised status bits
  logic refuse_sw; // Status write blocked
  // Memory array
  logic [7:0] mem_q [0:(2**ADDR_W)-1];
  // System domain
  logic [7:0] status_q; // Status register
  logic set_s1, set_s2, set_s3;
  logic clr_s1, clr_s2, clr_s3;
  logic srw_s1, srw_s2, srw_s3;
  logic m_s1, m_s2;

  assign byte_v = {sh_q, bus.si};
  // Hold freezes every serial clock update on the link side except the status copy
  assign byte_done = bus.hold_n && (bit_q == 3'h7);
  assign wel_s = st_s2[spn_pkg::ST_WEL];
  assign ppen_s = st_s2[spn_pkg::ST_PPEN];
  assign refuse_sw = !bus.wp_n && ppen_s;
  assign out_byte = (state_q == DS_SRD) ? st_s2 : mem_q[addr_q];

  // Status reaches the link side through two flops. It changes only after
  // the last clock edge of a selection, so the copy is settled before it is used.
  always_ff @(posedge bus.sck)
  begin
    st_s1 <= status_q;
    st_s2 <= st_s1;
  end

  // Select high acts as an asynchronous clear of the whole frame: the
  // clock path is dead while deselected and the next selection starts
  // at a command boundary. Cost: select rising during hold still ends
  // the frame.
  always_ff @(posedge bus.sck or posedge bus.cs_n)
  begin
    if (bus.cs_n)
    begin
      state_q <= DS_CMD;
      bit_q <= 3'h0;
      sh_q <= 7'h00;
      abyte_q <= 2'h0;
      addr_q <= '0;
      rd_q <= 1'b0;
      set_req_q <= 1'b0;
      clr_req_q <= 1'b0;
      srw_req_q <= 1'b0;
      srw_val_q <= 8'h00;
    end
    else if (bus.hold_n)
    begin
      // Input sampled here and by the array write, on the rising edge
      bit_q <= bit_q + 3'h1;
      sh_q <= byte_v[6:0];
      if (byte_done)
      begin
        case (state_q)
          DS_CMD:
          begin
            // One command per selection
            if (byte_v == spn_pkg::OP_SET_WEL)
            begin
              set_req_q <= 1'b1;
              state_q <= DS_SKIP;
            end
            else if (byte_v == spn_pkg::OP_CLR_WEL)
            begin
              clr_req_q <= 1'b1;
              state_q <= DS_SKIP;
            end
            else if (byte_v == spn_pkg::OP_STAT_RD)
              state_q <= DS_SRD;
            else if (byte_v == spn_pkg::OP_STAT_WR)
              state_q <= wel_s ? DS_SWR : DS_SKIP;
            else if (byte_v == spn_pkg::OP_MEM_RD)
            begin
              rd_q <= 1'b1;
              state_q <= DS_ADR;
            end
            else if (byte_v == spn_pkg::OP_MEM_WR)
            begin
              rd_q <= 1'b0;
              state_q <= DS_ADR;
            end
            else
              // Sleep has no action here; unknown codes end the frame
              state_q <= DS_SKIP;
          end
          DS_ADR:
          begin
            // Upper address bits fall off the top of the shifter
            addr_q <= {addr_q[ADDR_W-9:0], byte_v};
            abyte_q <= abyte_q + 2'h1;
            if (abyte_q == 2'(spn_pkg::ADDR_BYTES - 1))
              state_q <= rd_q ? DS_RD : DS_WR;
          end
          DS_WR, DS_RD:
            // Sequential bytes advance and wrap at the top
            addr_q <= addr_q + 1'b1;
          DS_SWR:
          begin
            if (!refuse_sw)
            begin
              srw_req_q <= 1'b1;
              srw_val_q <= byte_v;
            end
            state_q <= DS_SKIP;
          end
          default:
            state_q <= state_q; // Rest of selection ignored
        endcase
      end
    end
  end

  // Each byte lands on its eighth rising edge, so the write is over
  // before the next byte can arrive; there is no busy state at all.
  always_ff @(posedge bus.sck)
  begin
    if (!bus.cs_n && byte_done && (state_q == DS_WR) && wel_s)
      mem_q[addr_q] <= byte_v;
  end

  // Output shifts on the falling edge, MSB first
  always_ff @(negedge bus.sck or posedge bus.cs_n)
  begin
    if (bus.cs_n)
    begin
      drive_q <= 1'b0;
      so_q <= 1'b0;
    end
    else if (bus.hold_n)
    begin
      if ((state_q == DS_RD) || (state_q == DS_SRD))
      begin
        drive_q <= 1'b1;
        so_q <= out_byte[~bit_q];
      end
      else
      begin
        drive_q <= 1'b0;
        so_q <= 1'b0;
      end
    end
  end

  // Enable drops at once on hold or deselect
  assign bus.so_oe = drive_q && bus.hold_n && !bus.cs_n;
  assign bus.so = so_q;

  // Mode is the clock level seen as select falls
  always_ff @(negedge bus.cs_n)
  begin
    mode3_q <= bus.sck;
  end

  // Request levels cross into the system clock by two flops; the third
  // flop only serves the edge detect. A request stays up until the
  // selection ends, which outlasts the synchroniser many times.
  always_ff @(posedge ref_clk_in)
  begin
    set_s1 <= set_req_q;
    set_s2 <= set_s1;
    set_s3 <= set_s2;
    clr_s1 <= clr_req_q;
    clr_s2 <= clr_s1;
    clr_s3 <= clr_s2;
    srw_s1 <= srw_req_q;
    srw_s2 <= srw_s1;
    srw_s3 <= srw_s2;
    m_s1 <= mode3_q;
    m_s2 <= m_s1;
  end

  // Status register lives in the system domain so that reset works
  // even when the serial clock stands still
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
      status_q <= spn_pkg::ST_RST;
    else
    begin
      if (srw_s2 && !srw_s3)
        status_q <= (srw_val_q & spn_pkg::ST_WR_MASK)
          | (status_q & ~spn_pkg::ST_WR_MASK);
      else if (set_s2 && !set_s3)
        status_q[spn_pkg::ST_WEL] <= 1'b1;
      else if (clr_s2 && !clr_s3)
        status_q[spn_pkg::ST_WEL] <= 1'b0;
    end
  end

  // Status and mode seen by local logic
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      status_out <= spn_pkg::ST_RST;
      mode3_out <= 1'b0;
    end
    else
    begin
      status_out <= status_q;
      mode3_out <= m_s2;
    end
  end
endmodule : spn_dev
`default_nettype wire

// [test/spn_properties.sv]
`timescale 1ns/100ps
`default_nettype none
// Watches the serial link between the two ends
module spn_properties (
  input wire logic ref_clk_in, // System clock
  input wire logic rstn_in, // Synchronous reset, low
  input wire logic cs_n, // Chip select, low
  input wire logic sck, // Serial clock
  input wire logic si, // Master to device data
  input wire logic so, // Device data
  input wire logic so_oe, // Device drives so
  input wire logic wp_n, // Write protect, low
  input wire logic hold_n // Hold, low
);
  logic sck_q; // Serial clock one reference cycle ago
  logic sck_rise; // Serial clock rose since last sample
  logic [5:0] cnt_q; // Rising edges in this selection
  logic [7:0] op_q; // Command byte as seen on the wire
  logic is_mem; // Memory command
  logic is_stat; // Status command
  assign sck_rise = sck && !sck_q;
  assign is_mem = op_q == spn_pkg::OP_MEM_RD || op_q == spn_pkg::OP_MEM_WR;
  assign is_stat = op_q == spn_pkg::OP_STAT_RD || op_q == spn_pkg::OP_STAT_WR;
  // Edge detector; the host's clock is slow enough to be sampled
  always_ff @(posedge ref_clk_in)
    sck_q <= sck;
  // Edge count, cleared by deselect; held edges do not count
  always_ff @(posedge ref_clk_in)
    if (cs_n)
      cnt_q <= 6'h00;
    else if (sck_rise && hold_n)
      cnt_q <= cnt_q + 6'h01;
  // First eight bits form the command byte
  always_ff @(posedge ref_clk_in)
    if (!cs_n && sck_rise && hold_n && cnt_q < 6'h08)
      op_q <= {op_q[6:0], si};
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);
  idle_float_a: assert property (cs_n |-> !so_oe)
    else $error("output driven while deselected");
  hold_float_a: assert property (!hold_n |-> !so_oe)
    else $error("output driven during hold");
  read_only_drive_a: assert property (so_oe |->
    (op_q == spn_pkg::OP_STAT_RD && cnt_q >= 6'h08) ||
    (op_q == spn_pkg::OP_MEM_RD && cnt_q >= 6'h20))
    else $error("output driven outside read data");
  so_on_fall_a: assert property (so_oe && $past(so_oe) && $changed(so)
    |-> $fell(sck)) else $error("output moved off a falling edge");
  clock_idle_a: assert property (cs_n |-> !sck)
    else $error("serial clock high while deselected");
  select_lead_a: assert property ($fell(cs_n) |-> !sck [*3])
    else $error("clock rose too soon after select");
  hold_clock_low_a: assert property ($changed(hold_n) |-> !sck)
    else $error("hold moved while clock high");
  frame_length_a: assert property ($rose(cs_n) |->
    cnt_q == (is_mem ? spn_pkg::BITS_MEM : is_stat ? spn_pkg::BITS_STAT
    : spn_pkg::BITS_OP)) else $error("frame length wrong");
  address_pad_a: assert property (sck_rise && hold_n && !cs_n
    && is_mem && cnt_q >= 6'h08 && cnt_q < 6'h0E |-> !si)
    else $error("address pad bit not zero");
  select_gap_a: assert property ($rose(cs_n) |-> cs_n [*3])
    else $error("deselect too short");
endmodule : spn_properties
`default_nettype wire

// [test/spi_nvram_slave_port_test.sv]
`timescale 1ns/100ps
`default_nettype none
module spi_nvram_slave_port_test;
  logic ref_clk_in = 1'b0; // 250 MHz system clock
  logic rstn_in = 1'b0; // Reset, low
  logic cmd_valid = 1'b0; // Command offered
  logic cmd_ready; // Command taken
  logic [7:0] cmd_op = 8'h00; // Command code
  logic [17:0] cmd_addr = 18'h00000; // Byte location
  logic [7:0] cmd_data = 8'h00; // Write byte
  logic hold_req = 1'b0; // Pause request
  logic wp_n = 1'b1; // Write protect level
  logic rd_valid; // Read byte waiting
  logic rd_ready = 1'b0; // Take read byte
  logic [7:0] rd_data; // Read byte
  logic [7:0] status; // Device status
  logic mode3; // Mode of last selection
  int n_mismatch = 0; // Failed comparisons
  int check_count = 0; // All comparisons
  // Half period 2 ns
  always #2 ref_clk_in = ~ref_clk_in;
  spn_if bus_if ();
  spn_host u_spn_host (.bus(bus_if), .ref_clk_in, .rstn_in,
    .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready),
    .cmd_op_in(cmd_op), .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data),
    .hold_req_in(hold_req), .wp_n_in(wp_n), .rd_valid_out(rd_valid),
    .rd_ready_in(rd_ready), .rd_data_out(rd_data));
  spn_dev u_spn_dev (.bus(bus_if), .ref_clk_in, .rstn_in,
    .status_out(status), .mode3_out(mode3));
  spn_properties u_spn_properties (.ref_clk_in, .rstn_in,
    .cs_n(bus_if.cs_n), .sck(bus_if.sck), .si(bus_if.si), .so(bus_if.so),
    .so_oe(bus_if.so_oe), .wp_n(bus_if.wp_n), .hold_n(bus_if.hold_n));
  // Inputs always move 1 ns after the rising edge
  task automatic tick;
    @(posedge ref_clk_in);
    #1;
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Offer a command and hold it until the edge that takes it
  task automatic send(input logic [7:0] op, input logic [17:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    // Let an edge pass, so valid never drops and rises in one step
    tick();
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge ref_clk_in);
    while (cmd_ready !== 1'b1 && n < 2000)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    chk({7'h00, cmd_ready}, 8'h01);
    tick();
    cmd_valid = 1'b0;
  endtask : send
  // Wait for a read byte, compare it, then pop it
  task automatic pop(input logic [7:0] exp);
    int n;
    n = 0;
    @(negedge ref_clk_in);
    while (rd_valid !== 1'b1 && n < 2000)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    chk({7'h00, rd_valid}, 8'h01);
    chk(rd_data, exp);
    tick();
    rd_ready = 1'b1;
    tick();
    rd_ready = 1'b0;
  endtask : pop
  // Latch-free status read first, so the link sync fills
  task automatic t_reset_state;
    chk(status, spn_pkg::ST_RST);
    send(spn_pkg::OP_STAT_RD, 18'h00000, 8'h00);
    pop(spn_pkg::ST_RST);
  endtask : t_reset_state
  // Both ends of the array, write then read straight after
  task automatic t_mem_rw;
    send(spn_pkg::OP_SET_WEL, 18'h00000, 8'h00);
    send(spn_pkg::OP_MEM_WR, 18'h3FFFF, 8'hA5);
    send(spn_pkg::OP_MEM_WR, 18'h00000, 8'h5A);
    send(spn_pkg::OP_MEM_RD, 18'h3FFFF, 8'h00);
    pop(8'hA5);
    send(spn_pkg::OP_MEM_RD, 18'h00000, 8'h00);
    pop(8'h5A);
  endtask : t_mem_rw
  // A write without the latch leaves memory alone
  task automatic t_latch;
    send(spn_pkg::OP_CLR_WEL, 18'h00000, 8'h00);
    send(spn_pkg::OP_MEM_WR, 18'h00000, 8'h00);
    send(spn_pkg::OP_MEM_RD, 18'h00000, 8'h00);
    pop(8'h5A);
  endtask : t_latch
  // Status writes with and without the protect pin
  task automatic t_protect;
    send(spn_pkg::OP_SET_WEL, 18'h00000, 8'h00);
    send(spn_pkg::OP_STAT_WR, 18'h00000, 8'hFF);
    send(spn_pkg::OP_STAT_RD, 18'h00000, 8'h00);
    pop(8'h8E);
    chk(status, 8'h8E);
    wp_n = 1'b0;
    send(spn_pkg::OP_STAT_WR, 18'h00000, 8'h00);
    send(spn_pkg::OP_STAT_RD, 18'h00000, 8'h00);
    pop(8'h8E);
    wp_n = 1'b1;
    send(spn_pkg::OP_STAT_WR, 18'h00000, 8'h00);
    send(spn_pkg::OP_CLR_WEL, 18'h00000, 8'h00);
    send(spn_pkg::OP_STAT_RD, 18'h00000, 8'h00);
    pop(8'h00);
  endtask : t_protect
  // Unknown code and sleep give no answer and change nothing
  task automatic t_ignored;
    send(8'hFF, 18'h00000, 8'h00);
    repeat (100) tick();
    chk({7'h00, rd_valid}, 8'h00);
    send(spn_pkg::OP_SLEEP, 18'h00000, 8'h00);
    send(spn_pkg::OP_MEM_RD, 18'h00000, 8'h00);
    pop(8'h5A);
  endtask : t_ignored
  // Pause mid read; the byte arrives late but intact
  task automatic t_hold;
    send(spn_pkg::OP_MEM_RD, 18'h3FFFF, 8'h00);
    repeat (60) tick();
    hold_req = 1'b1;
    repeat (400) tick();
    chk({7'h00, rd_valid}, 8'h00);
    hold_req = 1'b0;
    pop(8'hA5);
  endtask : t_hold
  // Fill the read buffer; a third read must wait
  task automatic t_buffer;
    logic seen;
    seen = 1'b0;
    send(spn_pkg::OP_MEM_RD, 18'h00000, 8'h00);
    send(spn_pkg::OP_MEM_RD, 18'h3FFFF, 8'h00);
    repeat (400) tick();
    cmd_op = spn_pkg::OP_MEM_RD;
    cmd_valid = 1'b1;
    repeat (20)
    begin
      @(negedge ref_clk_in);
      seen = seen | (cmd_ready !== 1'b0);
    end
    tick();
    cmd_valid = 1'b0;
    chk({7'h00, seen}, 8'h00);
    pop(8'h5A);
    send(spn_pkg::OP_MEM_RD, 18'h00000, 8'h00);
    pop(8'hA5);
    pop(8'h5A);
    chk({7'h00, mode3}, 8'h00);
  endtask : t_buffer
  task automatic end_of_test;
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // Main sequence after three reset cycles
  initial
  begin
    repeat (3) @(posedge ref_clk_in);
    #1;
    rstn_in = 1'b1;
    t_reset_state();
    t_mem_rw();
    t_latch();
    t_protect();
    t_ignored();
    t_hold();
    t_buffer();
    end_of_test();
  end
  // About nine times the expected run
  initial
  begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
endmodule : spi_nvram_slave_port_test
`default_nettype wire
